// ==== ebct_pkg.sv ====
// Package for the expansion bus cycle timing block: port addresses, timing
// register indices and defaults, cycle kinds, engine states and carriers.
// Assumes only a SystemVerilog-2012 compiler; nothing is imported anywhere.
package ebct_pkg;

    // -------------------------------------------------------------------
    // I/O port addresses and field positions
    // -------------------------------------------------------------------
    localparam logic [15:0] PORT_INDEX_POINTER = 16'h0072;
    localparam logic [15:0] PORT_TIMING_VALUE  = 16'h0073;
    localparam int          FIELD_B0           = 2;
    localparam int          FIELD_B1           = 3;
    localparam int          FIELD_B2           = 6;
    localparam int          FIELD_B3           = 7;

    // -------------------------------------------------------------------
    // Timing register indices and reset values
    // -------------------------------------------------------------------
    localparam int          NUM_TIMING_REGS    = 13;
    localparam logic [3:0]  IDX_LE_DELAY       = 4'h0;
    localparam logic [3:0]  IDX_LE_WIDTH       = 4'h1;
    localparam logic [3:0]  IDX_UNUSED_TWO     = 4'h2;
    localparam logic [3:0]  IDX_NARROW_CMD     = 4'h3;
    localparam logic [3:0]  IDX_NARROW_WAIT    = 4'h4;
    localparam logic [3:0]  IDX_WIDE_IO_WAIT   = 4'h5;
    localparam logic [3:0]  IDX_WIDE_MEM_CMD   = 4'h6;
    localparam logic [3:0]  IDX_WIDE_MEM_WAIT_A = 4'h7;
    localparam logic [3:0]  IDX_WIDE_MEM_WAIT_B = 4'h8;
    localparam logic [3:0]  IDX_DRAM_RD_WAIT   = 4'h9;
    localparam logic [3:0]  IDX_DRAM_WR_WAIT   = 4'hA;
    localparam logic [3:0]  IDX_DRAM_WR_CMD    = 4'hB;
    localparam logic [3:0]  IDX_ONBOARD_CMD    = 4'hC;
    localparam logic [3:0]  IDX_LAST           = 4'hC;
    localparam logic [3:0]  DRAM_RD_CMD_DELAY  = 4'h0;
    localparam logic [3:0]  TIMING_RESET [NUM_TIMING_REGS] = '{
        4'h0, 4'h1, 4'h0, 4'h1, 4'h4, 4'h1, 4'h0,
        4'h1, 4'h0, 4'h0, 4'h1, 4'h0, 4'h1};

    // -------------------------------------------------------------------
    // Bus wait-state arithmetic and clock dividers
    // -------------------------------------------------------------------
    localparam logic [3:0]  WAIT_OFFSET        = 4'h2;
    localparam logic [1:0]  DIV_HIGH_SPEED     = 2'h3;
    localparam logic [1:0]  DIV_NORMAL         = 2'h1;
    localparam logic [4:0]  COUNT_MAX          = 5'h1F;

    // -------------------------------------------------------------------
    // Cycle kinds, engine states and carriers
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        KIND_MEM8    = 3'b000,
        KIND_IO8     = 3'b001,
        KIND_IO16    = 3'b010,
        KIND_MEM16   = 3'b011,
        KIND_DRAM    = 3'b100,
        KIND_ONBOARD = 3'b101
    } ebct_kind_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_DELAY = 3'b010,
        ST_CMD   = 3'b011,
        ST_DONE  = 3'b100
    } ebct_state_t;

    typedef struct packed {
        logic       ale;
        ebct_kind_t kind;
        logic       write;
    } ebct_cycle_t;

    typedef struct packed {
        logic bus_ale;
        logic bus_command_strobe;
        logic io_read_command;
        logic io_write_command;
        logic memory_write_command;
    } ebct_strobes_t;

    typedef struct packed {
        logic       is_value;
        logic [3:0] field;
    } ebct_port_write_t;

endpackage

// ==== ebct_bridge.sv ====
// Expansion bus cycle timing bridge: timing register file behind the pointer
// and value I/O ports, plus the engine that reshapes CPU local cycles.
// Assumes the CPU local cycle inputs are synchronous to mclk (the CPU clock)
// and that I/O port writes arrive on their own clock, io_clk.
//
// Behaviour
// - Generate bus latch enable, I/O commands, memory write and wait counts programmably.
// - Delays and widths count whole CPU clocks from the CPU address strobe.
// - Timing registers written indirectly via pointer port 072H and value port 073H.
// - Register index is pointer bits 7,6,3,2; bit 7 most significant.
// - Value port write stores bits 7,6,3,2 into the selected timing register.
// - Index 0 latch enable delay, index 1 its width, index 2 unused.
// - Command delays: index 3 narrow, 6 wide memory, 11 DRAM write, 12 on-board.
// - Wait counts: index 4, 5, 7/8, 9 and 10 by cycle kind.
// - Command delay counts from the CPU strobe trailing edge.
// - Recommended settings give latch enable one clock late, two wide.
// - Reset values are CPU clock counts for a 16 MHz CPU clock.
// - Bus wait states equal CPU wait states minus two, halved.
// - Cycle completion follows the wait count alone; no ready programming.
// - Expansion strobes meet slow bus timing while the CPU runs faster.
// - Bus clock is CPU clock over four, ALE aligned, in high speed; else halved.
`timescale 1ns/1ps

module ebct_bridge (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   io_clk,
    input  wire logic                   io_write_strobe,
    input  wire logic [15:0]            io_address,
    input  wire logic [7:0]             io_data,
    input  wire ebct_pkg::ebct_cycle_t  cpu_cycle,
    input  wire logic                   high_speed_osc_input,
    output      ebct_pkg::ebct_strobes_t bus_strobes,
    output      logic                   cycle_ready,
    output      logic [3:0]             bus_wait_states,
    output      logic                   expansion_bus_clock
);

    // -------------------------------------------------------------------
    // Helper functions
    // -------------------------------------------------------------------
    // Picks the four live bits of a port byte; the other bits are ignored.
    function automatic logic [3:0] field_of(input logic [7:0] b);
        field_of = {b[ebct_pkg::FIELD_B3], b[ebct_pkg::FIELD_B2],
                    b[ebct_pkg::FIELD_B1], b[ebct_pkg::FIELD_B0]};
    endfunction

    function automatic logic [3:0] cmd_index(input ebct_pkg::ebct_kind_t k,
                                             input logic w);
        case (k)
            ebct_pkg::KIND_MEM16:   cmd_index = ebct_pkg::IDX_WIDE_MEM_CMD;
            ebct_pkg::KIND_DRAM:    cmd_index = w ? ebct_pkg::IDX_DRAM_WR_CMD
                                                  : ebct_pkg::IDX_UNUSED_TWO;
            ebct_pkg::KIND_ONBOARD: cmd_index = ebct_pkg::IDX_ONBOARD_CMD;
            default:                cmd_index = ebct_pkg::IDX_NARROW_CMD;
        endcase
    endfunction

    function automatic logic [3:0] wait_index(input ebct_pkg::ebct_kind_t k,
                                              input logic w);
        case (k)
            ebct_pkg::KIND_IO16:    wait_index = ebct_pkg::IDX_WIDE_IO_WAIT;
            ebct_pkg::KIND_MEM16:   wait_index = w ? ebct_pkg::IDX_WIDE_MEM_WAIT_B
                                                   : ebct_pkg::IDX_WIDE_MEM_WAIT_A;
            ebct_pkg::KIND_DRAM:    wait_index = w ? ebct_pkg::IDX_DRAM_WR_WAIT
                                                   : ebct_pkg::IDX_DRAM_RD_WAIT;
            ebct_pkg::KIND_ONBOARD: wait_index = ebct_pkg::IDX_WIDE_IO_WAIT;
            default:                wait_index = ebct_pkg::IDX_NARROW_WAIT;
        endcase
    endfunction

    // Bus wait states from CPU-clock wait states, floored at zero.
    function automatic logic [3:0] bus_waits(input logic [3:0] cpu_waits);
        if (cpu_waits < ebct_pkg::WAIT_OFFSET) begin
            bus_waits = 4'h0;
        end else begin
            bus_waits = 4'((cpu_waits - ebct_pkg::WAIT_OFFSET) >> 1);
        end
    endfunction

    // -------------------------------------------------------------------
    // I/O port capture on io_clk
    // -------------------------------------------------------------------
    // The captured word is held until the next port write. The mclk side
    // reads it only after the toggle has settled, so it is quiet by then.
    ebct_pkg::ebct_port_write_t held_reg;
    ebct_pkg::ebct_port_write_t held_next;
    logic                       io_toggle_reg;
    logic                       io_toggle_next;
    logic                       io_rst_meta_reg;
    logic                       io_rst_reg;

    wire logic hit_pointer = io_write_strobe && (io_address == ebct_pkg::PORT_INDEX_POINTER);
    wire logic hit_value   = io_write_strobe && (io_address == ebct_pkg::PORT_TIMING_VALUE);
    wire logic hit_any     = hit_pointer || hit_value;

    assign held_next      = hit_any ? {hit_value, field_of(io_data)}
                                    : held_reg;
    assign io_toggle_next = hit_any ? ~io_toggle_reg : io_toggle_reg;

    always_ff @(posedge io_clk) begin
        io_rst_meta_reg <= rst;
        io_rst_reg      <= io_rst_meta_reg;
    end

    always_ff @(posedge io_clk) begin
        if (io_rst_reg) begin
            held_reg      <= '0;
            io_toggle_reg <= 1'b0;
        end else begin
            held_reg      <= held_next;
            io_toggle_reg <= io_toggle_next;
        end
    end

    // -------------------------------------------------------------------
    // Toggle crossing into mclk
    // -------------------------------------------------------------------
    logic tog_s1_reg;
    logic tog_s2_reg;
    logic tog_s3_reg;
    logic tog_seen_reg;

    wire logic port_event = (tog_s2_reg == tog_s3_reg) && (tog_s3_reg != tog_seen_reg);

    always_ff @(posedge mclk) begin
        if (rst) begin
            tog_s1_reg   <= 1'b0;
            tog_s2_reg   <= 1'b0;
            tog_s3_reg   <= 1'b0;
            tog_seen_reg <= 1'b0;
        end else begin
            tog_s1_reg   <= io_toggle_reg;
            tog_s2_reg   <= tog_s1_reg;
            tog_s3_reg   <= tog_s2_reg;
            tog_seen_reg <= port_event ? tog_s3_reg : tog_seen_reg;
        end
    end

    // -------------------------------------------------------------------
    // Pointer and timing register file
    // -------------------------------------------------------------------
    logic [3:0] pointer_reg;
    logic [3:0] pointer_next;
    logic [3:0] timing_reg [ebct_pkg::NUM_TIMING_REGS];

    // A value write leaves the pointer alone, so repeated writes land together.
    assign pointer_next = (port_event && !held_reg.is_value) ? held_reg.field
                                                             : pointer_reg;

    wire logic value_write = port_event && held_reg.is_value
                             && (pointer_reg <= ebct_pkg::IDX_LAST)
                             && (pointer_reg != ebct_pkg::IDX_UNUSED_TWO);

    always_ff @(posedge mclk) begin
        if (rst) begin
            pointer_reg <= 4'h0;
        end else begin
            pointer_reg <= pointer_next;
        end
    end

    always_ff @(posedge mclk) begin
        for (int i = 0; i < ebct_pkg::NUM_TIMING_REGS; i++) begin
            if (rst) begin
                timing_reg[i] <= ebct_pkg::TIMING_RESET[i];
            end else if (value_write && (pointer_reg == 4'(i))) begin
                timing_reg[i] <= held_reg.field;
            end
        end
    end

    // -------------------------------------------------------------------
    // Cycle engine on mclk
    // -------------------------------------------------------------------
    ebct_pkg::ebct_state_t   state_reg;
    ebct_pkg::ebct_state_t   state_next;
    ebct_pkg::ebct_cycle_t   cyc_reg;
    ebct_pkg::ebct_cycle_t   cyc_next;
    logic                    ale_prev_reg;
    logic [4:0]              le_cnt_reg;
    logic [4:0]              le_cnt_next;
    logic [4:0]              cnt_reg;
    logic [4:0]              cnt_next;
    ebct_pkg::ebct_strobes_t strobes_next;
    logic                    ready_next;

    wire logic ale_rise = cpu_cycle.ale && !ale_prev_reg;
    wire logic ale_fall = !cpu_cycle.ale && ale_prev_reg;

    wire logic [3:0] le_delay  = timing_reg[ebct_pkg::IDX_LE_DELAY];
    wire logic [3:0] le_width  = timing_reg[ebct_pkg::IDX_LE_WIDTH];
    wire logic [3:0] cmd_sel   = cmd_index(cyc_reg.kind, cyc_reg.write);
    wire logic [3:0] wait_sel  = wait_index(cyc_reg.kind, cyc_reg.write);
    // The unused slot is never written; a DRAM read takes the zero DRAM_RD_CMD_DELAY in its place.
    wire logic [3:0] cmd_delay = (cmd_sel == ebct_pkg::IDX_UNUSED_TWO)
                                 ? ebct_pkg::DRAM_RD_CMD_DELAY : timing_reg[cmd_sel];
    wire logic [3:0] wait_cnt  = timing_reg[wait_sel];

    wire logic [4:0] le_end    = 5'(le_delay) + 5'(le_width);
    wire logic       le_active = (state_reg != ebct_pkg::ST_IDLE)
                                 && (le_cnt_reg >= 5'(le_delay))
                                 && (le_cnt_reg < le_end);
    wire logic       on_bus    = (cyc_reg.kind != ebct_pkg::KIND_DRAM)
                                 && (cyc_reg.kind != ebct_pkg::KIND_ONBOARD);
    wire logic       is_io     = (cyc_reg.kind == ebct_pkg::KIND_IO8)
                                 || (cyc_reg.kind == ebct_pkg::KIND_IO16);
    wire logic       cmd_start = (state_reg == ebct_pkg::ST_DELAY)
                                 && (cnt_reg == 5'(cmd_delay));
    wire logic       cmd_end   = (state_reg == ebct_pkg::ST_CMD)
                                 && (cnt_reg == 5'(wait_cnt));
    wire logic       cmd_on    = cmd_start
                                 || ((state_reg == ebct_pkg::ST_CMD) && !cmd_end);

    // Next state of the cycle engine.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ebct_pkg::ST_IDLE: begin
                if (ale_rise) begin
                    state_next = ebct_pkg::ST_ADDR;
                end
            end
            ebct_pkg::ST_ADDR: begin
                if (ale_fall) begin
                    state_next = ebct_pkg::ST_DELAY;
                end
            end
            ebct_pkg::ST_DELAY: begin
                if (cmd_start) begin
                    state_next = ebct_pkg::ST_CMD;
                end
            end
            ebct_pkg::ST_CMD: begin
                if (cmd_end) begin
                    state_next = ebct_pkg::ST_DONE;
                end
            end
            ebct_pkg::ST_DONE: begin
                state_next = ebct_pkg::ST_IDLE;
            end
            default: begin
                state_next = ebct_pkg::ST_IDLE;
            end
        endcase
    end

    assign cyc_next    = ale_rise && (state_reg == ebct_pkg::ST_IDLE) ? cpu_cycle : cyc_reg;
    assign le_cnt_next = ale_rise && (state_reg == ebct_pkg::ST_IDLE) ? 5'h00
                         : (le_cnt_reg == ebct_pkg::COUNT_MAX) ? le_cnt_reg
                         : le_cnt_reg + 5'h01;
    assign cnt_next    = (ale_fall || cmd_start) ? 5'h00
                         : (cnt_reg == ebct_pkg::COUNT_MAX) ? cnt_reg
                         : cnt_reg + 5'h01;

    // Strobes are registered so the expansion side never sees decode glitches.
    assign strobes_next.bus_ale              = le_active && on_bus;
    assign strobes_next.bus_command_strobe   = cmd_on && on_bus;
    assign strobes_next.io_read_command      = cmd_on && is_io && !cyc_reg.write;
    assign strobes_next.io_write_command     = cmd_on && is_io && cyc_reg.write;
    assign strobes_next.memory_write_command = cmd_on && on_bus && !is_io && cyc_reg.write;
    assign ready_next                        = cmd_end;

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg    <= ebct_pkg::ST_IDLE;
            cyc_reg      <= '0;
            ale_prev_reg <= 1'b0;
            le_cnt_reg   <= 5'h00;
            cnt_reg      <= 5'h00;
            bus_strobes  <= '0;
            cycle_ready  <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cyc_reg      <= cyc_next;
            ale_prev_reg <= cpu_cycle.ale;
            le_cnt_reg   <= le_cnt_next;
            cnt_reg      <= cnt_next;
            bus_strobes  <= strobes_next;
            cycle_ready  <= ready_next;
        end
    end

    // -------------------------------------------------------------------
    // Bus wait-state report
    // -------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            bus_wait_states <= 4'h0;
        end else begin
            bus_wait_states <= bus_waits(wait_cnt);
        end
    end

    // -------------------------------------------------------------------
    // Expansion bus clock
    // -------------------------------------------------------------------
    // In high speed the divider restarts at each ALE so that the bus clock
    // phase tracks the command strobes; the normal divider runs free.
    logic [1:0] div_reg;
    logic [1:0] div_next;
    logic       bus_clk_next;

    wire logic [1:0] div_top = high_speed_osc_input ? ebct_pkg::DIV_HIGH_SPEED
                                                    : ebct_pkg::DIV_NORMAL;
    assign div_next     = (high_speed_osc_input && ale_rise) ? 2'h0
                          : (div_reg >= div_top) ? 2'h0 : div_reg + 2'h1;
    assign bus_clk_next = high_speed_osc_input ? (div_next < 2'h2)
                                               : (div_next == 2'h0);

    always_ff @(posedge mclk) begin
        if (rst) begin
            div_reg             <= 2'h0;
            expansion_bus_clock <= 1'b0;
        end else begin
            div_reg             <= div_next;
            expansion_bus_clock <= bus_clk_next;
        end
    end

endmodule

// ==== ebct_bridge_checker.sv ====
// Concurrent checks on the ports of the bus cycle timing bridge.
// Assumes all outputs are registered on mclk and rst is synchronous.
`timescale 1ns/1ps
module ebct_bridge_checker (
    input wire logic                    mclk,
    input wire logic                    rst,
    input wire logic                    io_clk,
    input wire logic                    io_write_strobe,
    input wire logic [15:0]             io_address,
    input wire logic [7:0]              io_data,
    input wire ebct_pkg::ebct_cycle_t   cpu_cycle,
    input wire logic                    high_speed_osc_input,
    input wire ebct_pkg::ebct_strobes_t bus_strobes,
    input wire logic                    cycle_ready,
    input wire logic [3:0]              bus_wait_states,
    input wire logic                    expansion_bus_clock
);
    // ------------
    // History
    // ------------
    // In high speed the divider restarts on a CPU strobe, so its checks wait for quiet spells.
    logic [5:0] busy_hist;
    logic [3:0] hs_hist;
    wire        ior = bus_strobes.io_read_command;
    wire        iow = bus_strobes.io_write_command;
    wire        memw = bus_strobes.memory_write_command;
    wire        cmd = bus_strobes.bus_command_strobe;
    wire        ebc = expansion_bus_clock;
    wire        hs = high_speed_osc_input;
    always_ff @(posedge mclk) begin
        busy_hist <= {busy_hist[4:0], rst | cpu_cycle.ale};
        hs_hist <= {hs_hist[2:0], hs};
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ------------
    // Properties
    // ------------
    cmd_qualify_a: assert property ((ior || iow || memw) |-> cmd)
        else $error("command line without bus command strobe");
    io_exclusive_a: assert property (!(ior && iow))
        else $error("io read and write together");
    memw_alone_a: assert property (memw |-> !ior && !iow)
        else $error("memory write beside an io command");
    ready_pulse_a: assert property (cycle_ready |=> !cycle_ready)
        else $error("ready longer than one clock");
    ready_end_a: assert property ($fell(cmd) |-> cycle_ready)
        else $error("command ended without ready");
    wait_range_a: assert property (bus_wait_states <= 4'h6)
        else $error("bus wait states out of range");
    reset_quiet_a: assert property ($past(rst) |-> bus_strobes == '0 && !cycle_ready)
        else $error("strobe active after reset");
    slow_div_a: assert property (!hs && hs_hist == 4'h0 && busy_hist == 6'h0
        |-> ebc != $past(ebc))
        else $error("bus clock not at half rate");
    fast_div_a: assert property (hs && hs_hist == 4'hF && busy_hist == 6'h0
        |-> !(ebc == $past(ebc) && ebc == $past(ebc, 2)))
        else $error("bus clock not at quarter rate");
endmodule

bind ebct_bridge ebct_bridge_checker chk_u (
    .mclk(mclk), .rst(rst), .io_clk(io_clk), .io_write_strobe(io_write_strobe),
    .io_address(io_address), .io_data(io_data), .cpu_cycle(cpu_cycle),
    .high_speed_osc_input(high_speed_osc_input), .bus_strobes(bus_strobes),
    .cycle_ready(cycle_ready), .bus_wait_states(bus_wait_states),
    .expansion_bus_clock(expansion_bus_clock)
);

// ==== ebct_board_model.sv ====
// Expansion board model: watches the bus strobes and times them.
// Assumes strobes are synchronous to mclk; restart clears the records.
`timescale 1ns/1ps
module ebct_board_model (
    input wire logic                    mclk,
    input wire logic                    restart,
    input wire ebct_pkg::ebct_strobes_t strobes,
    output int                          ale_at,
    output int                          ale_len,
    output int                          cmd_at,
    output int                          cmd_len,
    output logic [2:0]                  seen_cmds
);
    int   now = 0;
    logic ale_q = 1'b0;
    logic cmd_q = 1'b0;
    // Edges are counted like the bench counts them, so positions compare directly.
    always @(posedge mclk) begin
        now <= now + 1;
        ale_q <= strobes.bus_ale;
        cmd_q <= strobes.bus_command_strobe;
        if (restart) begin
            ale_at <= -1;
            ale_len <= 0;
            cmd_at <= -1;
            cmd_len <= 0;
            seen_cmds <= 3'h0;
        end else begin
            if (strobes.bus_ale && !ale_q) ale_at <= now;
            if (strobes.bus_ale) ale_len <= ale_len + 1;
            if (strobes.bus_command_strobe && !cmd_q) cmd_at <= now;
            if (strobes.bus_command_strobe) cmd_len <= cmd_len + 1;
            seen_cmds <= seen_cmds | {strobes.io_read_command,
                strobes.io_write_command, strobes.memory_write_command};
        end
    end
endmodule

// ==== tb.sv ====
// Self-checking bench for the bus cycle timing bridge.
// Assumes the package, bridge, checker and board model are compiled first.
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [2:0] kind;
        logic       wr;
        logic [3:0] dly;
        logic [3:0] wt;
        logic       isbus;
        logic [2:0] cmds;
    } ebct_row_t;
    logic                    mclk = 1'b0;
    logic                    io_clk = 1'b0;
    logic                    rst = 1'b1;
    logic                    io_write_strobe = 1'b0;
    logic [15:0]             io_address = 16'h0000;
    logic [7:0]              io_data = 8'h00;
    ebct_pkg::ebct_cycle_t   cpu_cycle = '0;
    logic                    high_speed_osc_input = 1'b0;
    logic                    restart = 1'b0;
    ebct_pkg::ebct_strobes_t bus_strobes;
    logic                    cycle_ready;
    logic [3:0]              bus_wait_states;
    logic                    expansion_bus_clock;
    int                      ale_at, ale_len, cmd_at, cmd_len;
    logic [2:0]              seen_cmds;
    int                      cyc = 0;
    int                      fail_count = 0;
    int                      n_checks = 0;
    // Default timings per cycle kind; cmds is {io read, io write, memory write}.
    ebct_row_t               rows [11] = '{
        '{3'h0, 1'b0, 4'h1, 4'h4, 1'b1, 3'h0}, '{3'h0, 1'b1, 4'h1, 4'h4, 1'b1, 3'h1},
        '{3'h1, 1'b0, 4'h1, 4'h4, 1'b1, 3'h4}, '{3'h1, 1'b1, 4'h1, 4'h4, 1'b1, 3'h2},
        '{3'h2, 1'b0, 4'h1, 4'h1, 1'b1, 3'h4}, '{3'h2, 1'b1, 4'h1, 4'h1, 1'b1, 3'h2},
        '{3'h3, 1'b0, 4'h0, 4'h1, 1'b1, 3'h0}, '{3'h3, 1'b1, 4'h0, 4'h0, 1'b1, 3'h1},
        '{3'h4, 1'b0, 4'h0, 4'h0, 1'b0, 3'h0}, '{3'h4, 1'b1, 4'h0, 4'h1, 1'b0, 3'h0},
        '{3'h5, 1'b0, 4'h1, 4'h1, 1'b0, 3'h0}};

    ebct_bridge dut_u (
        .mclk(mclk), .rst(rst), .io_clk(io_clk), .io_write_strobe(io_write_strobe),
        .io_address(io_address), .io_data(io_data), .cpu_cycle(cpu_cycle),
        .high_speed_osc_input(high_speed_osc_input), .bus_strobes(bus_strobes),
        .cycle_ready(cycle_ready), .bus_wait_states(bus_wait_states),
        .expansion_bus_clock(expansion_bus_clock)
    );
    ebct_board_model board_u (
        .mclk(mclk), .restart(restart), .strobes(bus_strobes), .ale_at(ale_at),
        .ale_len(ale_len), .cmd_at(cmd_at), .cmd_len(cmd_len), .seen_cmds(seen_cmds)
    );

    // ------------
    // Clocks and helpers
    // ------------
    always @(posedge mclk) cyc <= cyc + 1;
    initial begin
        forever #2 mclk = ~mclk;
    end
    initial begin
        #5.3;
        forever #62.5 io_clk = ~io_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Unused data bits are set on purpose, so a decoder using them shows up.
    task automatic io_wr(input logic [15:0] a, input logic [3:0] v);
        @(posedge io_clk);
        io_write_strobe <= 1'b1;
        io_address <= a;
        io_data <= {v[3:2], 2'h3, v[1:0], 2'h3};
        @(posedge io_clk);
        io_write_strobe <= 1'b0;
        repeat (3) @(posedge io_clk);
    endtask

    task automatic set_reg(input logic [3:0] idx, input logic [3:0] v);
        io_wr(16'h0072, idx);
        io_wr(16'h0073, v);
    endtask

    task automatic run_cyc(input ebct_row_t r, input int r0, input int r1);
        int t0;
        int t1;
        int tr;
        int w;
        w = int'(r.wt);
        tr = -1;
        restart <= 1'b1;
        @(posedge mclk);
        restart <= 1'b0;
        cpu_cycle <= '{1'b1, ebct_pkg::ebct_kind_t'(r.kind), r.wr};
        t0 = cyc;
        repeat (3) @(posedge mclk);
        cpu_cycle.ale <= 1'b0;
        t1 = cyc;
        for (int i = 0; i < 80 && tr < 0; i++) begin
            @(posedge mclk);
            if (cycle_ready === 1'b1) tr = cyc;
        end
        @(posedge mclk);
        chk(tr, t1 + r.dly + w + 4);
        chk({28'h0, bus_wait_states}, w < 2 ? 0 : (w - 2) / 2);
        chk({29'h0, seen_cmds}, 32'(r.cmds));
        chk(ale_len, r.isbus ? r1 : 0);
        chk(cmd_len, r.isbus ? w + 1 : 0);
        if (r.isbus) begin
            chk(ale_at, t0 + r0 + 3);
            chk(cmd_at, t1 + r.dly + 3);
        end
    endtask

    task automatic clk_count(input logic hs, input int exp);
        int   n;
        logic p;
        high_speed_osc_input <= hs;
        repeat (8) @(posedge mclk);
        p = expansion_bus_clock;
        n = 0;
        repeat (32) begin
            @(posedge mclk);
            n += int'(expansion_bus_clock !== p);
            p = expansion_bus_clock;
        end
        chk(n, exp);
    endtask

    // ------------
    // Sequence
    // ------------
    initial begin
        repeat (100) @(posedge mclk);
        rst <= 1'b0;
        repeat (100) @(posedge mclk);
        chk({28'h0, bus_wait_states}, 1);
        foreach (rows[i]) run_cyc(rows[i], 0, 1);
        io_wr(16'h0063, 4'h8);
        set_reg(4'h0, 4'h1);
        set_reg(4'h1, 4'h2);
        set_reg(4'h6, 4'h2);
        set_reg(4'h7, 4'h4);
        set_reg(4'hA, 4'h3);
        set_reg(4'hB, 4'h2);
        run_cyc('{3'h3, 1'b0, 4'h2, 4'h4, 1'b1, 3'h0}, 1, 2);
        run_cyc('{3'h4, 1'b1, 4'h2, 4'h3, 1'b0, 3'h0}, 1, 2);
        set_reg(4'h0, 4'h3);
        io_wr(16'h0073, 4'h2);
        io_wr(16'h0074, 4'h1);
        set_reg(4'hF, 4'h9);
        run_cyc('{3'h3, 1'b0, 4'h2, 4'h4, 1'b1, 3'h0}, 2, 2);
        cpu_cycle.ale <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b1;
        cpu_cycle.ale <= 1'b0;
        repeat (100) @(posedge mclk);
        rst <= 1'b0;
        repeat (100) @(posedge mclk);
        run_cyc(rows[6], 0, 1);
        clk_count(1'b0, 32);
        clk_count(1'b1, 16);
        give_verdict();
    end

    // The whole run needs about 15 us; over eight times that means a hang.
    initial begin
        #125000;
        fail_count++;
        give_verdict();
    end
endmodule
